// ===== hw/sed_pkg.sv
// shared constants, types and opcode decoding for both ends of the serial link
package sed_pkg;

	// ******************************************************************
	// timing
	// ******************************************************************
	localparam int CLK_PERIOD_NS = 5;
	// host serial clock period, well under every per-opcode frequency limit
	localparam int HOST_SCLK_PERIOD_NS = 120;
	localparam int SCLK_HALF_CYCLES = (HOST_SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);
	// highest link rates the opcodes allow, in MHz
	localparam int LINK_MAX_MHZ_GENERAL = 166;
	localparam int LINK_MAX_MHZ_RESUME = 100;

	// ******************************************************************
	// framing
	// ******************************************************************
	localparam int ADDR_BYTES = 4;
	localparam int OTP_REGION_BYTES = 1024;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ADDR_BYTE_LAST = 2'(ADDR_BYTES - 1);

	typedef logic [7:0] sed_byte_type;
	typedef logic [31:0] sed_addr_type;
	typedef logic [10:0] sed_count_type;

	// ******************************************************************
	// opcodes
	// ******************************************************************
	localparam sed_byte_type OP_SMALL_SECTOR_ERASE = 8'h21;
	localparam sed_byte_type OP_LARGE_SECTOR_ERASE = 8'hdc;
	localparam sed_byte_type OP_WHOLE_ARRAY_ERASE_A = 8'h60;
	localparam sed_byte_type OP_WHOLE_ARRAY_ERASE_B = 8'hc7;
	localparam sed_byte_type OP_ERASE_RESULT_CHECK = 8'hd0;
	localparam sed_byte_type OP_SECTOR_WEAR_COUNT_READ = 8'h5d;
	localparam sed_byte_type OP_OPERATION_SUSPEND = 8'hb0;
	localparam sed_byte_type OP_OPERATION_RESUME = 8'h7a;
	localparam sed_byte_type OP_OTP_REGION_PROGRAM = 8'h42;
	localparam sed_byte_type OP_OTP_REGION_READ = 8'h4b;
	localparam sed_byte_type OP_VOLATILE_PROTECT_READ = 8'he0;
	localparam sed_byte_type OP_VOLATILE_PROTECT_WRITE = 8'he1;
	localparam sed_byte_type OP_PERSISTENT_PROTECT_READ = 8'he2;
	localparam sed_byte_type OP_PERSISTENT_PROTECT_PROGRAM = 8'he3;
	localparam sed_byte_type OP_PERSISTENT_PROTECT_CLEAR_ALL = 8'he4;

	// opcodes carrying four address bytes after the opcode
	function automatic logic opHasAddr(input sed_byte_type op);
		case (op)
			OP_SMALL_SECTOR_ERASE, OP_LARGE_SECTOR_ERASE: opHasAddr = 1'b1;
			OP_ERASE_RESULT_CHECK, OP_SECTOR_WEAR_COUNT_READ: opHasAddr = 1'b1;
			OP_OTP_REGION_PROGRAM, OP_OTP_REGION_READ: opHasAddr = 1'b1;
			OP_VOLATILE_PROTECT_READ, OP_VOLATILE_PROTECT_WRITE: opHasAddr = 1'b1;
			OP_PERSISTENT_PROTECT_READ, OP_PERSISTENT_PROTECT_PROGRAM: opHasAddr = 1'b1;
			default: opHasAddr = 1'b0;
		endcase
	endfunction

	// opcode-only transactions
	function automatic logic opNoAddr(input sed_byte_type op);
		case (op)
			OP_WHOLE_ARRAY_ERASE_A, OP_WHOLE_ARRAY_ERASE_B: opNoAddr = 1'b1;
			OP_OPERATION_SUSPEND, OP_OPERATION_RESUME: opNoAddr = 1'b1;
			OP_PERSISTENT_PROTECT_CLEAR_ALL: opNoAddr = 1'b1;
			default: opNoAddr = 1'b0;
		endcase
	endfunction

	// modifying opcodes that need the write enable latch
	function automatic logic opNeedsWel(input sed_byte_type op);
		case (op)
			OP_SMALL_SECTOR_ERASE, OP_LARGE_SECTOR_ERASE: opNeedsWel = 1'b1;
			OP_WHOLE_ARRAY_ERASE_A, OP_WHOLE_ARRAY_ERASE_B: opNeedsWel = 1'b1;
			OP_OTP_REGION_PROGRAM, OP_VOLATILE_PROTECT_WRITE: opNeedsWel = 1'b1;
			OP_PERSISTENT_PROTECT_PROGRAM: opNeedsWel = 1'b1;
			OP_PERSISTENT_PROTECT_CLEAR_ALL: opNeedsWel = 1'b1;
			default: opNeedsWel = 1'b0;
		endcase
	endfunction

	// opcodes where the device shifts bytes out after the address
	function automatic logic opReadsOut(input sed_byte_type op);
		case (op)
			OP_SECTOR_WEAR_COUNT_READ, OP_OTP_REGION_READ: opReadsOut = 1'b1;
			OP_VOLATILE_PROTECT_READ, OP_PERSISTENT_PROTECT_READ: opReadsOut = 1'b1;
			default: opReadsOut = 1'b0;
		endcase
	endfunction

	// opcodes where the host shifts data bytes in after the address
	function automatic logic opTakesData(input sed_byte_type op);
		opTakesData = (op == OP_OTP_REGION_PROGRAM) || (op == OP_VOLATILE_PROTECT_WRITE);
	endfunction

endpackage

// ===== hw/sed_link_if.sv
// single-lane serial link between host controller and flash command decoder
`timescale 1ns/1ps
`default_nettype none
interface sed_link_if;
	logic sclk; // serial clock made by the host
	logic csN; // chip select, frames a transaction
	logic mosi; // host to device data
	logic miso; // device to host data
	logic misoOe; // device drives miso

	modport device (input sclk, input csN, input mosi, output miso, output misoOe);
	modport host (output sclk, output csN, output mosi, input miso, input misoOe);
endinterface
`default_nettype wire

// ===== hw/sed_device_end.sv
// device end: decodes erase, suspend, secure region and protection transactions
// Behaviour
// - 21h plus address erases a small sector
// - DCh plus address erases a large sector
// - 60h or C7h alone erases whole array
// - D0h plus address checks last sector erase
// - 5Dh plus address shifts out wear count
// - B0h alone suspends program, erase or check
// - 7Ah alone resumes suspended operation
// - 42h, address, byte stream programs secure region
// - 4Bh plus address reads secure region bytes
// - E0h plus address reads volatile protection
// - E1h, address, one byte writes volatile protection
// - E2h plus address reads persistent protection
// - E3h plus address sets persistent protection bit
// - E4h alone clears all persistent protection bits
`timescale 1ns/1ps
`default_nettype none
module sed_device_end
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	sed_link_if.device link, // serial link
	input wire logic welSet, // write enable latch level from the flash core
	output logic cmdValid, // pulse: a command header was accepted
	output sed_pkg::sed_byte_type cmdOpcode, // accepted opcode
	output sed_pkg::sed_addr_type cmdAddr, // accepted address, zero if none
	output logic cmdIgnored, // pulse: opcode refused or unknown
	output logic dataValid, // pulse: one data byte received
	output sed_pkg::sed_byte_type dataByte, // received data byte
	input wire sed_pkg::sed_byte_type rdData, // next byte to shift out
	output logic rdAdvance // pulse: rdData taken, present the next
);
	import sed_pkg::*;

	typedef enum {ST_OPCODE, ST_ADDR, ST_DATAIN, ST_DATAOUT, ST_IGNORE} sed_dev_state_type;

	// ******************************************************************
	// pin synchronisers
	// ******************************************************************
	logic sclkMeta, sclkSync, sclkLast;
	logic csNMeta, csNSync;
	logic mosiMeta, mosiSync;
	logic sclkRise, sclkFall;

	// two flops on every pin, a third on sclk for edges; the first stage is never looked at
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclkMeta <= 1'b0;
			sclkSync <= 1'b0;
			sclkLast <= 1'b0;
			csNMeta <= 1'b1;
			csNSync <= 1'b1;
			mosiMeta <= 1'b0;
			mosiSync <= 1'b0;
		end
		else
		begin
			sclkMeta <= link.sclk;
			sclkSync <= sclkMeta;
			sclkLast <= sclkSync;
			csNMeta <= link.csN;
			csNSync <= csNMeta;
			mosiMeta <= link.mosi;
			mosiSync <= mosiMeta;
		end
	end

	// edges of the serial clock, only inside a frame
	assign sclkRise = sclkSync & ~sclkLast & ~csNSync;
	assign sclkFall = ~sclkSync & sclkLast & ~csNSync;

	// ******************************************************************
	// input byte assembly
	// ******************************************************************
	logic [2:0] bitCnt;
	sed_byte_type inShift;
	sed_byte_type rxNow;
	logic byteDone;

	assign rxNow = {inShift[6:0], mosiSync};
	assign byteDone = sclkRise && (bitCnt == BIT_LAST);

	// msb first, one bit per rising edge; select high restarts alignment
	always_ff @(posedge clk)
	begin
		if (rst || csNSync)
		begin
			bitCnt <= 3'h0;
			inShift <= 8'h00;
		end
		else if (sclkRise)
		begin
			inShift <= rxNow;
			bitCnt <= bitCnt + 3'h1;
		end
	end

	// ******************************************************************
	// transaction sequencer
	// ******************************************************************
	sed_dev_state_type state;
	logic [1:0] addrCnt;

	// header decode; an unknown or refused opcode sinks the rest of the frame
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= ST_OPCODE;
			addrCnt <= 2'h0;
			cmdValid <= 1'b0;
			cmdIgnored <= 1'b0;
			cmdOpcode <= 8'h00;
			cmdAddr <= 32'h0000_0000;
		end
		else if (csNSync)
		begin
			state <= ST_OPCODE;
			addrCnt <= 2'h0;
			cmdValid <= 1'b0;
			cmdIgnored <= 1'b0;
		end
		else
		begin
			cmdValid <= 1'b0;
			cmdIgnored <= 1'b0;
			if (byteDone)
			begin
				case (state)
					ST_OPCODE:
					begin
						cmdOpcode <= rxNow;
						cmdAddr <= 32'h0000_0000;
						if (!opHasAddr(rxNow) && !opNoAddr(rxNow))
						begin
							state <= ST_IGNORE;
							cmdIgnored <= 1'b1;
						end
						else if (opNeedsWel(rxNow) && !welSet)
						begin
							state <= ST_IGNORE;
							cmdIgnored <= 1'b1;
						end
						else if (opHasAddr(rxNow))
						begin
							state <= ST_ADDR;
						end
						else
						begin
							// opcode-only commands act as soon as the byte is in
							state <= ST_IGNORE;
							cmdValid <= 1'b1;
						end
					end
					ST_ADDR:
					begin
						// most significant address byte arrives first
						cmdAddr <= {cmdAddr[23:0], rxNow};
						addrCnt <= addrCnt + 2'h1;
						if (addrCnt == ADDR_BYTE_LAST)
						begin
							cmdValid <= 1'b1;
							if (opReadsOut(cmdOpcode))
								state <= ST_DATAOUT;
							else if (opTakesData(cmdOpcode))
								state <= ST_DATAIN;
							else
								state <= ST_IGNORE;
						end
					end
					ST_DATAIN:
					begin
						// the volatile protection write takes exactly one byte
						if (cmdOpcode == OP_VOLATILE_PROTECT_WRITE)
							state <= ST_IGNORE;
					end
					ST_DATAOUT, ST_IGNORE:
					begin
						state <= state;
					end
					default:
					begin
						state <= ST_IGNORE;
					end
				endcase
			end
		end
	end

	// ******************************************************************
	// write data path
	// ******************************************************************
	// program stream runs until select rises; the core wraps the region
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dataValid <= 1'b0;
			dataByte <= 8'h00;
		end
		else
		begin
			dataValid <= byteDone && (state == ST_DATAIN) && !csNSync;
			if (byteDone && (state == ST_DATAIN))
				dataByte <= rxNow;
		end
	end

	// ******************************************************************
	// read data path
	// ******************************************************************
	logic [2:0] outCnt;
	sed_byte_type outShift;

	// bits change on falling edges so the host samples them on rising ones
	always_ff @(posedge clk)
	begin
		if (rst || csNSync)
		begin
			outCnt <= 3'h0;
			outShift <= 8'h00;
			rdAdvance <= 1'b0;
			link.miso <= 1'b0;
			link.misoOe <= 1'b0;
		end
		else
		begin
			rdAdvance <= 1'b0;
			if ((state == ST_DATAOUT) && sclkFall)
			begin
				link.misoOe <= 1'b1;
				outCnt <= outCnt + 3'h1;
				if (outCnt == 3'h0)
				begin
					link.miso <= rdData[7];
					outShift <= {rdData[6:0], 1'b0};
					rdAdvance <= 1'b1;
				end
				else
				begin
					link.miso <= outShift[7];
					outShift <= {outShift[6:0], 1'b0};
				end
			end
		end
	end

endmodule // sed_device_end
`default_nettype wire

// ===== hw/sed_host_end.sv
// host end: frames opcode, address and data bytes onto the serial link
`timescale 1ns/1ps
`default_nettype none
module sed_host_end
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	sed_link_if.host link, // serial link
	input wire logic start, // pulse: begin a transaction when idle
	input wire sed_pkg::sed_byte_type opcode, // opcode to send
	input wire sed_pkg::sed_addr_type addr, // address, used if the opcode has one
	input wire sed_pkg::sed_count_type dataCount, // data bytes to write or read
	input wire sed_pkg::sed_byte_type txByte, // next data byte to write
	output logic txAdvance, // pulse: txByte taken, present the next
	output logic rxValid, // pulse: one byte read from the device
	output sed_pkg::sed_byte_type rxByte, // byte read
	output logic busy, // transaction in progress
	output logic done // pulse: select released
);
	import sed_pkg::*;

	typedef enum {HS_IDLE, HS_SHIFT, HS_HOLD} sed_host_state_type;

	// ******************************************************************
	// state
	// ******************************************************************
	sed_host_state_type state;
	logic [3:0] halfCnt;
	logic [13:0] bitNum, hdrBits, totalBits;
	logic [39:0] hdrShift;
	sed_byte_type txShift, rxShift;
	logic reading, misoMeta, misoSync, halfEnd;
	logic [10:0] effCount;

	// data length the opcode really uses
	always_comb
	begin
		effCount = 11'h000;
		if (opcode == OP_VOLATILE_PROTECT_WRITE)
			effCount = 11'h001;
		else if (opTakesData(opcode) || opReadsOut(opcode))
			effCount = dataCount;
	end

	assign halfEnd = (halfCnt == SCLK_HALF_LAST);

	// miso comes from another module's flops; two stages before use
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			misoMeta <= 1'b0;
			misoSync <= 1'b0;
		end
		else
		begin
			misoMeta <= link.miso;
			misoSync <= misoMeta;
		end
	end

	// ******************************************************************
	// framing sequencer
	// ******************************************************************
	// clock from a divider; mosi moves on falling edges, miso sampled on rising
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= HS_IDLE;
			halfCnt <= 4'h0;
			bitNum <= 14'h0000;
			hdrBits <= 14'h0000;
			totalBits <= 14'h0000;
			hdrShift <= 40'h00_0000_0000;
			txShift <= 8'h00;
			rxShift <= 8'h00;
			reading <= 1'b0;
			txAdvance <= 1'b0;
			rxValid <= 1'b0;
			rxByte <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			link.sclk <= 1'b0;
			link.csN <= 1'b1;
			link.mosi <= 1'b0;
		end
		else
		begin
			txAdvance <= 1'b0;
			rxValid <= 1'b0;
			done <= 1'b0;
			halfCnt <= halfEnd ? 4'h0 : halfCnt + 4'h1;
			case (state)
				HS_IDLE:
				begin
					halfCnt <= 4'h0;
					if (start)
					begin
						state <= HS_SHIFT;
						busy <= 1'b1;
						link.csN <= 1'b0;
						bitNum <= 14'h0000;
						reading <= opReadsOut(opcode);
						// address bytes follow the opcode, most significant first
						hdrBits <= opHasAddr(opcode) ? 14'd40 : 14'd8;
						totalBits <= (opHasAddr(opcode) ? 14'd40 : 14'd8) + {effCount, 3'h0};
						hdrShift <= {opcode[6:0], addr, 1'b0};
						link.mosi <= opcode[7];
					end
				end
				HS_SHIFT:
				begin
					if (halfEnd && !link.sclk)
					begin
						// rising edge: device samples mosi, host samples miso
						link.sclk <= 1'b1;
						bitNum <= bitNum + 14'h0001;
						if (reading && (bitNum >= hdrBits))
						begin
							rxShift <= {rxShift[6:0], misoSync};
							if (bitNum[2:0] == 3'h7)
							begin
								rxValid <= 1'b1;
								rxByte <= {rxShift[6:0], misoSync};
							end
						end
					end
					else if (halfEnd)
					begin
						link.sclk <= 1'b0;
						if (bitNum == totalBits)
							state <= HS_HOLD;
						else if (bitNum < hdrBits)
						begin
							link.mosi <= hdrShift[39];
							hdrShift <= {hdrShift[38:0], 1'b0};
						end
						else if (reading)
							link.mosi <= 1'b0;
						else if (bitNum[2:0] == 3'h0)
						begin
							link.mosi <= txByte[7];
							txShift <= {txByte[6:0], 1'b0};
							txAdvance <= 1'b1;
						end
						else
						begin
							link.mosi <= txShift[7];
							txShift <= {txShift[6:0], 1'b0};
						end
					end
				end
				HS_HOLD:
				begin
					// half a clock with select high before the next frame
					link.csN <= 1'b1;
					link.mosi <= 1'b0;
					if (halfEnd && link.csN)
					begin
						state <= HS_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
				default:
				begin
					state <= HS_IDLE;
				end
			endcase
		end
	end

endmodule // sed_host_end
`default_nettype wire

// ===== dv/sed_link_asserts.sv
// link protocol checker for the serial flash command link
`timescale 1ns/1ps
`default_nettype none
module sed_link_asserts
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic sclk, // serial clock
	input wire logic csN, // chip select
	input wire logic mosi, // host data
	input wire logic miso, // device data
	input wire logic misoOe // device drives miso
);
	// ******************************************************************
	// helper: rising serial clock edges in the current frame
	// ******************************************************************
	logic sclkQ;
	logic [15:0] bitCnt;
	// count survives until the sample where select rises, so partial bytes show
	always_ff @(posedge clk)
	begin
		sclkQ <= sclk;
		if (rst || csN)
			bitCnt <= 16'h0000;
		else if (sclk && !sclkQ)
			bitCnt <= bitCnt + 16'h0001;
	end

	// ******************************************************************
	// properties
	// ******************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_sclk_idle_low: assert property (csN |-> !sclk)
		else $error("serial clock high outside a frame");
	a_mosi_stable_high: assert property (sclk && !csN |-> $stable(mosi))
		else $error("host data moved while serial clock high");
	a_sclk_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*4] ##1 !sclk)
		else $error("serial clock high phase not 12 cycles");
	a_sclk_low_time: assert property ($fell(sclk) && !csN |-> !sclk[*8] ##1 !sclk[*4])
		else $error("serial clock low phase too short");
	a_select_setup: assert property ($fell(csN) |-> !sclk[*8] ##1 !sclk[*4])
		else $error("first clock edge too soon after select");
	a_miso_stable_high: assert property (sclk && misoOe && $past(misoOe) |-> $stable(miso))
		else $error("device data moved while serial clock high");
	a_miso_after_fall: assert property ($changed(miso) && misoOe |-> !sclk && !$past(sclk, 2))
		else $error("device data changed too close to a clock fall");
	a_oe_off_unselected: assert property (csN && $past(csN, 4) |-> !misoOe)
		else $error("device drives data while not selected");
	a_whole_bytes: assert property ($rose(csN) |-> bitCnt[2:0] == 3'h0 && bitCnt != 16'h0000)
		else $error("frame not a whole number of bytes");

	// main scenarios reached
	c_read_out: cover property ($rose(misoOe));
	c_header_frame: cover property ($rose(csN) && bitCnt == 16'h0028);
	c_data_frame: cover property ($rose(csN) && bitCnt > 16'h0028);
endmodule // sed_link_asserts
`default_nettype wire

// ===== dv/spi_erase_protect_cmd_decoder_bench.sv
// self-checking bench: host end drives device end across the link
`timescale 1ns/1ps
`default_nettype none
module spi_erase_protect_cmd_decoder_bench;
	import sed_pkg::*;
	// one transaction: stimulus beside what it should produce
	typedef struct packed {
		sed_byte_type op;
		sed_addr_type addr;
		sed_count_type cnt;
		logic wel;
		logic noAddr;
		logic expIgn;
		logic [3:0] nData;
		logic [3:0] nRx;
	} sed_row_type;

	logic clk, rst, welSet, start;
	sed_byte_type opcode, txByte, rdData, expD, expR;
	sed_addr_type addr;
	sed_count_type dataCount;
	logic cmdValid, cmdIgnored, dataValid, rdAdvance, txAdvance, rxValid, busy, done;
	sed_byte_type cmdOpcode, dataByte, rxByte;
	sed_addr_type cmdAddr;
	int miscompares, nCompared, nValid, nIgn, nData, nRx, nDone;
	sed_link_if link();

	sed_device_end sed_device_end_inst (.clk(clk), .rst(rst), .link(link), .welSet(welSet),
		.cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
		.cmdIgnored(cmdIgnored), .dataValid(dataValid), .dataByte(dataByte),
		.rdData(rdData), .rdAdvance(rdAdvance));
	sed_host_end sed_host_end_inst (.clk(clk), .rst(rst), .link(link), .start(start),
		.opcode(opcode), .addr(addr), .dataCount(dataCount), .txByte(txByte),
		.txAdvance(txAdvance), .rxValid(rxValid), .rxByte(rxByte), .busy(busy), .done(done));
	sed_link_asserts sed_link_asserts_inst (.clk(clk), .rst(rst), .sclk(link.sclk),
		.csN(link.csN), .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe));

	// ******************************************************************
	// common tasks
	// ******************************************************************
	task automatic final_report();
		$display("counts: %0d compared, %0d mismatched", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nCompared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// start held for hold cycles; a second start while busy must be dropped
	task automatic runTxn(input sed_row_type r, input int hold);
		int k;
		@(posedge clk);
		nValid = 0;
		nIgn = 0;
		nData = 0;
		nRx = 0;
		nDone = 0;
		expD = 8'h30;
		expR = 8'hc0;
		welSet <= r.wel;
		opcode <= r.op;
		addr <= r.addr;
		dataCount <= r.cnt;
		txByte <= 8'h30;
		rdData <= 8'hc0;
		start <= 1'b1;
		repeat (hold) @(posedge clk);
		start <= 1'b0;
		for (k = 0; k < 6000 && nDone == 0; k++)
			@(posedge clk);
		if (nDone == 0)
		begin
			miscompares++;
			final_report();
		end
		check(32'(nValid), r.expIgn ? 32'h0 : 32'h1, "accepted");
		check(32'(nIgn), 32'(r.expIgn), "refused");
		if (!r.expIgn)
		begin
			check(32'(cmdOpcode), 32'(r.op), "opcode");
			check(cmdAddr, r.noAddr ? 32'h0 : r.addr, "address");
		end
		check(32'(nData), 32'(r.nData), "data bytes");
		check(32'(nRx), 32'(r.nRx), "read bytes");
		$display("test op %h done", r.op);
	endtask

	// ******************************************************************
	// monitor: counts pulses, checks byte streams, feeds next bytes
	// ******************************************************************
	always @(posedge clk)
	begin
		if (cmdValid === 1'b1) nValid++;
		if (cmdIgnored === 1'b1) nIgn++;
		if (done === 1'b1) nDone++;
		if (dataValid === 1'b1)
		begin
			check(32'(dataByte), 32'(expD), "data byte");
			expD = expD + 8'h01;
			nData++;
		end
		if (rxValid === 1'b1)
		begin
			check(32'(rxByte), 32'(expR), "read byte");
			expR = expR + 8'h01;
			nRx++;
		end
		if (txAdvance === 1'b1) txByte <= txByte + 8'h01;
		if (rdAdvance === 1'b1) rdData <= rdData + 8'h01;
	end

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ******************************************************************
	// main sequence
	// ******************************************************************
	sed_row_type rows [0:14] = '{
		'{8'h21, 32'h1234_5678, 11'h000, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0},
		'{8'hdc, 32'h89ab_cdef, 11'h000, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0},
		'{8'h60, 32'h55aa_55aa, 11'h000, 1'b1, 1'b1, 1'b0, 4'h0, 4'h0},
		'{8'hc7, 32'h0f0f_0f0f, 11'h000, 1'b1, 1'b1, 1'b0, 4'h0, 4'h0},
		'{8'hd0, 32'h0004_0000, 11'h000, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0},
		'{8'h5d, 32'h0000_1000, 11'h002, 1'b0, 1'b0, 1'b0, 4'h0, 4'h2},
		'{8'hb0, 32'h1111_1111, 11'h000, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0},
		'{8'h7a, 32'h2222_2222, 11'h000, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0},
		'{8'h42, 32'h0000_0010, 11'h003, 1'b1, 1'b0, 1'b0, 4'h3, 4'h0},
		'{8'h4b, 32'h0000_03f0, 11'h003, 1'b0, 1'b0, 1'b0, 4'h0, 4'h3},
		'{8'he0, 32'h0008_0000, 11'h001, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1},
		'{8'he1, 32'h0008_0000, 11'h001, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0},
		'{8'he2, 32'hfffc_0000, 11'h001, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1},
		'{8'he3, 32'h0100_0000, 11'h000, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0},
		'{8'he4, 32'h3333_3333, 11'h000, 1'b1, 1'b1, 1'b0, 4'h0, 4'h0}};
	sed_byte_type wrOps [0:7] = '{8'h21, 8'hdc, 8'h60, 8'hc7, 8'h42, 8'he1, 8'he3, 8'he4};

	initial
	begin
		rst <= 1'b1;
		welSet <= 1'b0;
		start <= 1'b0;
		opcode <= 8'h00;
		addr <= 32'h0;
		dataCount <= 11'h000;
		txByte <= 8'h00;
		rdData <= 8'h00;
		miscompares = 0;
		nCompared = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 15; i++)
			runTxn(rows[i], 1);
		// every write-type opcode with the latch clear, data sent anyway for 42h and E1h
		foreach (wrOps[j])
			runTxn('{wrOps[j], 32'h0000_0100, 11'h002, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0}, 1);
		// unknown opcode is refused
		runTxn('{8'h99, 32'h0, 11'h000, 1'b1, 1'b1, 1'b1, 4'h0, 4'h0}, 1);
		// single-byte write: extra count must not stream more bytes
		runTxn('{8'he1, 32'h0000_4000, 11'h003, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0}, 1);
		// stream that ends exactly at the top of the secure region, back to back
		runTxn('{8'h42, 32'h0000_03f8, 11'h008, 1'b1, 1'b0, 1'b0, 4'h8, 4'h0}, 1);
		// start held while busy: only one frame may follow
		runTxn('{8'hb0, 32'h0, 11'h000, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0}, 3);
		repeat (40) @(posedge clk);
		check(32'(busy), 32'h0, "no second frame");
		check(32'(nValid), 32'h1, "one command");
		$display("test busy start done");
		// reset in the middle of a read frame; idle reset would leave nothing to undo
		addr <= 32'h0000_0200;
		opcode <= OP_OTP_REGION_READ;
		dataCount <= 11'h008;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int k = 0; k < 6000 && link.misoOe !== 1'b1; k++)
			@(posedge clk);
		check(32'(link.misoOe), 32'h1, "read phase reached");
		check(cmdAddr, 32'h0000_0200, "address before reset");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		@(posedge clk);
		check(32'(cmdOpcode), 32'h0, "opcode after reset");
		check(cmdAddr, 32'h0, "address after reset");
		check(32'(link.csN), 32'h1, "select after reset");
		check(32'(link.misoOe), 32'h0, "output enable after reset");
		check(32'(busy), 32'h0, "busy after reset");
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		$display("test reset done");
		runTxn(rows[0], 1);
		final_report();
	end
endmodule // spi_erase_protect_cmd_decoder_bench
`default_nettype wire
